// >>> fwsr_ctrl.sv
/*
 Host controller for a parallel NOR flash: issues program and erase command
 sequences, polls the write status byte and recovers from failures.
 Assumes an APB master on pclk and the flash pins wired to the engine ports.
*/
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module fwsr_ctrl
   import fwsr_pkg::*;
#(
   parameter int AW = 20
)
(
   // Clock and reset.
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave.
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Flash pins.
   output logic [AW-1:0]      flash_addr,
   output logic [7:0]         dq_out,
   input  wire logic [7:0]    dq_in,
   output logic               dq_oe_n,
   output logic               ce_n,
   output logic               oe_n,
   output logic               we_n,
   input  wire logic          ready_busy_output,
   // Interrupt.
   output logic               irq
);
   // Address must hold the fixed command addresses.
   if (AW < 12 || AW > 32)
   begin : g_aw_check
      $error("fwsr_ctrl: AW must be 12 to 32");
   end
   // Sequencer states.
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SEQ  = 3'b001,
      S_RD_A = 3'b010,
      S_RD_B = 3'b011,
      S_WIN  = 3'b100,
      S_PRE  = 3'b101,
      S_POST = 3'b110,
      S_RST  = 3'b111
   } fwsr_st_e;
   fwsr_bus_if #(.AW(AW)) fb ();
   fwsr_st_e         st;          // Sequencer state.
   fwsr_cmd_e        cmd;         // Command in progress.
   logic [2:0]       idx;         // Step within the write sequence.
   logic [AW-1:0]    user_addr;   // Target address from software.
   logic [7:0]       user_data;   // Program byte from software.
   logic [7:0]       first_rd;    // First of a pair of status reads.
   logic [7:0]       last_rd;     // Most recent status byte.
   logic             recheck;     // Flag was seen; one more pair decides.
   logic             accepted;    // Erase sequence was seen toggling or with the polling bit low.
   logic             window;      // Last erase window bit read.
   logic [IRQ_W-1:0] irq_st;      // Sticky events.
   logic [IRQ_W-1:0] irq_en;      // Event enables.
   logic [IRQ_W-1:0] ev;          // Events this cycle.
   logic             rb_s1;       // Ready/busy synchroniser stage one.
   logic             rb_s2;       // Ready/busy synchroniser stage two.
   // Bus decode.
   wire        setup   = psel & ~penable;
   wire        wr_en   = psel & penable & pwrite & pready;
   wire        hit     = (paddr == OFS_CTRL) | (paddr == OFS_ADDR) | (paddr == OFS_WDATA)
                       | (paddr == OFS_STATUS) | (paddr == OFS_IRQ_ST)
                       | (paddr == OFS_IRQ_CL) | (paddr == OFS_IRQ_EN);
   wire        start   = wr_en & (paddr == OFS_CTRL) & (st == S_IDLE)
                       & (pwdata[2:0] != 3'h0) & (pwdata[2:0] != 3'h7);
   wire [31:0] status  = {16'h0, rb_s2, accepted, window, recheck, st, cmd == C_NONE,
                          last_rd};
   wire [31:0] rd_mux  = (paddr == OFS_CTRL)   ? {29'h0, cmd} :
                         (paddr == OFS_ADDR)   ? 32'(user_addr) :
                         (paddr == OFS_WDATA)  ? {24'h0, user_data} :
                         (paddr == OFS_STATUS) ? status :
                         (paddr == OFS_IRQ_ST) ? {29'h0, irq_st} :
                         (paddr == OFS_IRQ_EN) ? {29'h0, irq_en} : 32'h0;
   // Flash request decode.
   wire fwsr_step_s step   = seq_step(cmd, idx);
   wire        tog_seen = first_rd[BIT_TOG1] ^ fb.rdata[BIT_TOG1];
   assign fb.req   = (st != S_IDLE);
   assign fb.wr    = (st == S_SEQ) | (st == S_RST);
   assign fb.addr  = (st == S_SEQ && !step.use_user) ? AW'(step.addr) : user_addr;
   assign fb.wdata = (st == S_RST) ? D_RST :
                     (cmd == C_PROG && step.last) ? user_data : step.data;
   fwsr_bus_engine #(.AW(AW)) u_engine (
      .pclk       (pclk),
      .presetn    (presetn),
      .fb         (fb),
      .flash_addr (flash_addr),
      .dq_out     (dq_out),
      .dq_in      (dq_in),
      .dq_oe_n    (dq_oe_n),
      .ce_n       (ce_n),
      .oe_n       (oe_n),
      .we_n       (we_n)
   );
   // APB answer: data and ready are set up in the setup cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= setup ? rd_mux : 32'h0;
      end
   end
   // Software registers, ready/busy synchroniser and interrupt.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         user_addr <= '0;
         user_data <= 8'h00;
         irq_en    <= '0;
         irq_st    <= '0;
         irq       <= 1'b0;
         rb_s1     <= 1'b1;
         rb_s2     <= 1'b1;
      end
      else
      begin
         rb_s1 <= ready_busy_output;
         rb_s2 <= rb_s1;
         if (wr_en && paddr == OFS_ADDR)
         begin
            user_addr <= pwdata[AW-1:0];
         end
         if (wr_en && paddr == OFS_WDATA)
         begin
            user_data <= pwdata[7:0];
         end
         if (wr_en && paddr == OFS_IRQ_EN)
         begin
            irq_en <= pwdata[IRQ_W-1:0];
         end
         // A new event wins over a clear in the same cycle.
         irq_st <= (irq_st & ~((wr_en && paddr == OFS_IRQ_CL) ? pwdata[IRQ_W-1:0] : '0)) | ev;
         irq    <= |(irq_st & irq_en);
      end
   end
   // Sequencer: command writes, status polling and recovery.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st       <= S_IDLE;
         cmd      <= C_NONE;
         idx      <= 3'h0;
         first_rd <= 8'h00;
         last_rd  <= 8'h00;
         recheck  <= 1'b0;
         accepted <= 1'b0;
         window   <= 1'b0;
         ev       <= '0;
      end
      else
      begin
         ev <= '0;
         if (start)
         begin
            cmd     <= fwsr_cmd_e'(pwdata[2:0]);
            idx     <= 3'h0;
            recheck <= 1'b0;
            // Adding a sector first checks the window is still open.
            st <= (pwdata[2:0] == C_ADD)  ? S_PRE :
                  (pwdata[2:0] == C_POLL) ? S_RD_A : S_SEQ;
            if (pwdata[2:0] == C_SERASE)
            begin
               accepted <= 1'b0;
            end
         end
         else if (fb.done)
         begin
            if (!fb.wr)
            begin
               last_rd <= fb.rdata;
            end
            unique case (st)
               S_SEQ:
               begin
                  idx <= idx + 3'h1;
                  if (step.last)
                  begin
                     // Chip erase is polled to the end; no window applies.
                     st <= (cmd == C_RESET) ? S_IDLE :
                           (cmd == C_ADD)   ? S_POST : S_RD_A;
                     ev[IRQ_DONE] <= (cmd == C_RESET);
                  end
               end
               S_RD_A:
               begin
                  first_rd <= fb.rdata;
                  st       <= S_RD_B;
               end
               S_RD_B:
               begin
                  if (cmd == C_SERASE && !accepted)
                  begin
                     // Acceptance by toggle or polling bit, then read the window.
                     accepted <= tog_seen | ~fb.rdata[BIT_POLL];
                     st       <= S_WIN;
                  end
                  else if (!tog_seen)
                  begin
                     st           <= S_IDLE;
                     ev[IRQ_DONE] <= 1'b1;
                  end
                  else if (recheck)
                  begin
                     // Still toggling after the flag: failed, send reset.
                     st           <= S_RST;
                     ev[IRQ_FAIL] <= 1'b1;
                  end
                  else
                  begin
                     recheck <= fb.rdata[BIT_TLIM];
                     st      <= S_RD_A;
                  end
               end
               S_WIN:
               begin
                  window       <= fb.rdata[BIT_WIN];
                  st           <= S_IDLE;
                  ev[IRQ_DONE] <= 1'b1;
               end
               S_PRE:
               begin
                  window <= fb.rdata[BIT_WIN];
                  // A closed window would ignore the add.
                  if (fb.rdata[BIT_WIN])
                  begin
                     st          <= S_IDLE;
                     ev[IRQ_REJ] <= 1'b1;
                  end
                  else
                  begin
                     st <= S_SEQ;
                  end
               end
               S_POST:
               begin
                  window       <= fb.rdata[BIT_WIN];
                  st           <= S_IDLE;
                  ev[IRQ_DONE] <= 1'b1;
                  ev[IRQ_REJ]  <= fb.rdata[BIT_WIN];
               end
               default:
               begin
                  st           <= S_IDLE;
                  ev[IRQ_DONE] <= 1'b1;
               end
            endcase
         end
      end
   end
   // A failure is followed by the reset command write within 40 clocks of entering S_RST.
   a_fail_then_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (st == S_RD_B && fb.done && tog_seen && recheck && cmd != C_SERASE)
      |=> (st == S_RST) ##[1:40] (fb.done && fb.wr && fb.wdata == D_RST))
      else $error("reset command not issued after failure");
   a_status_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (fb.req && !fb.wr && !ce_n && !oe_n) |-> (flash_addr == user_addr))
      else $error("status read at wrong address");
   a_fail_recheck: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ev[IRQ_FAIL]) |-> $past(recheck) && $past(st) == S_RD_B)
      else $error("failure declared without recheck");
   a_window_after: assert property (@(posedge pclk) disable iff (!presetn)
      (st == S_WIN) |-> (cmd == C_SERASE) && $past(st == S_RD_B || st == S_WIN))
      else $error("window read before acceptance check");
   a_add_prechk: assert property (@(posedge pclk) disable iff (!presetn)
      (start && pwdata[2:0] == C_ADD) |=> (st == S_PRE) ##1 (fb.req && !fb.wr))
      else $error("added sector not preceded by window read");
   a_rej_source: assert property (@(posedge pclk) disable iff (!presetn)
      ev[IRQ_REJ] |-> cmd == C_ADD && window && $past(fb.done))
      else $error("reject raised without closed window");
endmodule : fwsr_ctrl

// >>> fwsr_pkg.sv
/*
 Constants, types and command steps for the flash write-status host controller.
 Assumes a 250 MHz pclk and an 8-bit flash data bus.
*/
package fwsr_pkg;
   // Clock period in picoseconds.
   localparam int CLK_PS   = 4000;
   // Flash bus timing in nanoseconds, with derived cycle counts rounded up.
   localparam int T_RD_NS  = 70;
   localparam int T_WR_NS  = 45;
   localparam int T_GAP_NS = 30;
   localparam int RD_CYC   = (T_RD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WR_CYC   = (T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int GAP_CYC  = (T_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SYNC_CYC = 2;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_ST = 8'h10;
   localparam logic [7:0] OFS_IRQ_CL = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   // Status byte bit positions on the flash data bus.
   localparam int BIT_POLL = 7;
   localparam int BIT_TOG1 = 6;
   localparam int BIT_TLIM = 5;
   localparam int BIT_WIN  = 3;
   localparam int BIT_TOG2 = 2;
   // Interrupt bit positions and width.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_REJ  = 2;
   localparam int IRQ_W    = 3;
   // Fixed command addresses and data bytes.
   localparam logic [11:0] UNL_A1 = 12'h555;
   localparam logic [11:0] UNL_A2 = 12'h2aa;
   localparam logic [7:0]  D_UNL1 = 8'haa;
   localparam logic [7:0]  D_UNL2 = 8'h55;
   localparam logic [7:0]  D_PROG = 8'ha0;
   localparam logic [7:0]  D_ERS  = 8'h80;
   localparam logic [7:0]  D_SECT = 8'h30;
   localparam logic [7:0]  D_CHIP = 8'h10;
   localparam logic [7:0]  D_RST  = 8'hf0;
   // Commands written to the control register.
   typedef enum logic [2:0] {
      C_NONE   = 3'h0,
      C_PROG   = 3'h1,
      C_SERASE = 3'h2,
      C_ADD    = 3'h3,
      C_CHIP   = 3'h4,
      C_RESET  = 3'h5,
      C_POLL   = 3'h6
   } fwsr_cmd_e;
   // One write step of a command sequence.
   typedef struct packed {
      logic        last;
      logic        use_user;
      logic [11:0] addr;
      logic [7:0]  data;
   } fwsr_step_s;
   // Returns step idx of the write sequence for a command.
   function automatic fwsr_step_s seq_step(input fwsr_cmd_e cmd, input logic [2:0] idx);
      fwsr_step_s s;
      s = '{last: 1'b1, use_user: 1'b1, addr: UNL_A1, data: D_RST};
      unique case (idx)
         3'h0:    s = '{1'b0, 1'b0, UNL_A1, D_UNL1};
         3'h1:    s = '{1'b0, 1'b0, UNL_A2, D_UNL2};
         3'h2:    s = '{cmd == C_PROG ? 1'b0 : 1'b0, 1'b0, UNL_A1,
                        cmd == C_PROG ? D_PROG : D_ERS};
         3'h3:    s = (cmd == C_PROG) ? '{1'b1, 1'b1, UNL_A1, D_RST}
                                      : '{1'b0, 1'b0, UNL_A1, D_UNL1};
         3'h4:    s = '{1'b0, 1'b0, UNL_A2, D_UNL2};
         default: s = (cmd == C_CHIP) ? '{1'b1, 1'b0, UNL_A1, D_CHIP}
                                      : '{1'b1, 1'b1, UNL_A1, D_SECT};
      endcase
      if (cmd == C_ADD)
      begin
         s = '{1'b1, 1'b1, UNL_A1, D_SECT};
      end
      else if (cmd == C_RESET)
      begin
         s = '{1'b1, 1'b1, UNL_A1, D_RST};
      end
      return s;
   endfunction : seq_step
endpackage : fwsr_pkg

// >>> fwsr_bus_if.sv
/*
 Carrier between the sequencer and the flash bus cycle engine.
 Assumes both ends run on pclk; req is held until the done pulse.
*/
`timescale 1ns/1ps
interface fwsr_bus_if #(parameter int AW = 20);
   logic          req;    // Cycle wanted; held until done.
   logic          wr;     // High for a write cycle.
   logic [AW-1:0] addr;   // Flash address.
   logic [7:0]    wdata;  // Write byte.
   logic          done;   // One-cycle end of cycle.
   logic [7:0]    rdata;  // Byte read, valid with done.
   modport ctrl   (output req, wr, addr, wdata, input done, rdata);
   modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface : fwsr_bus_if

// >>> fwsr_bus_engine.sv
/*
 Flash bus cycle engine: runs one timed read or write cycle on the flash pins.
 Assumes dq_in comes from the pin, unsynchronised; every pin output is a flop.
*/
`timescale 1ns/1ps
module fwsr_bus_engine
   import fwsr_pkg::*;
#(
   parameter int AW = 20
)
(
   // Clock and reset.
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Sequencer side.
   fwsr_bus_if.engine         fb,
   // Flash pins.
   output logic [AW-1:0]      flash_addr,
   output logic [7:0]         dq_out,
   input  wire logic [7:0]    dq_in,
   output logic               dq_oe_n,
   output logic               ce_n,
   output logic               oe_n,
   output logic               we_n
);
   // Engine states.
   typedef enum logic [1:0] {E_IDLE = 2'b00, E_ACT = 2'b01, E_GAP = 2'b10} fwsr_eng_e;
   fwsr_eng_e  st;       // Current engine state.
   logic [5:0] cnt;      // Cycles left in the current phase.
   logic [7:0] dq_s1;    // First synchroniser stage.
   logic [7:0] dq_s2;    // Second synchroniser stage.
   logic       wr_q;     // Latched direction.
   // Read strobe covers access time plus the synchroniser delay.
   localparam logic [5:0] RD_LOAD  = 6'(RD_CYC + SYNC_CYC - 1);
   localparam logic [5:0] WR_LOAD  = 6'(WR_CYC - 1);
   localparam logic [5:0] GAP_LOAD = 6'(GAP_CYC - 1);
   wire last_cnt = (cnt == 6'h00);
   // Two-flop synchroniser for the data pins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end
      else
      begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
      end
   end
   // Cycle sequencing: strobe phase, then recovery gap, then done.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st         <= E_IDLE;
         cnt        <= 6'h00;
         wr_q       <= 1'b0;
         flash_addr <= '0;
         dq_out     <= 8'h00;
         dq_oe_n    <= 1'b1;
         ce_n       <= 1'b1;
         oe_n       <= 1'b1;
         we_n       <= 1'b1;
         fb.done    <= 1'b0;
         fb.rdata   <= 8'h00;
      end
      else
      begin
         fb.done <= 1'b0;
         unique case (st)
            E_IDLE:
            begin
               // Latch the request and open the strobe. While done stands, the
               // request still belongs to the step just finished, so wait a cycle.
               if (fb.req && !fb.done)
               begin
                  st         <= E_ACT;
                  wr_q       <= fb.wr;
                  flash_addr <= fb.addr;
                  dq_out     <= fb.wdata;
                  dq_oe_n    <= ~fb.wr;
                  ce_n       <= 1'b0;
                  oe_n       <= fb.wr;
                  we_n       <= ~fb.wr;
                  cnt        <= fb.wr ? WR_LOAD : RD_LOAD;
               end
            end
            E_ACT:
            begin
               // Close strobes; data stays driven through the gap for hold.
               if (last_cnt)
               begin
                  st   <= E_GAP;
                  cnt  <= GAP_LOAD;
                  ce_n <= 1'b1;
                  oe_n <= 1'b1;
                  we_n <= 1'b1;
                  if (!wr_q)
                  begin
                     fb.rdata <= dq_s2;
                  end
               end
               else
               begin
                  cnt <= cnt - 6'h01;
               end
            end
            default:
            begin
               // End of recovery: release the bus and report.
               if (last_cnt)
               begin
                  st      <= E_IDLE;
                  dq_oe_n <= 1'b1;
                  fb.done <= 1'b1;
               end
               else
               begin
                  cnt <= cnt - 6'h01;
               end
            end
         endcase
      end
   end
endmodule : fwsr_bus_engine

// >>> fwsr_flash_model.sv
/*
 Behavioural flash device that answers the controller's strobes with array data
 or the write status byte. Assumes one array byte and times in ns of sim time.
*/
`timescale 1ns/1ps
module fwsr_flash_model
#(
   parameter real WIN_NS = 1500.0, // Sector erase window.
   parameter real ERS_NS = 2000.0, // Erase time after the window.
   parameter real PRG_NS = 500.0   // Program time.
)
(
   // Controller pins.
   input  wire logic [7:0] dq_out,
   input  wire logic       ce_n,
   input  wire logic       oe_n,
   input  wire logic       we_n,
   // Device outputs.
   output logic [7:0]      dq_in,
   output logic            ready_busy_output
);
   logic [7:0] mem  = 8'hff; // The array byte.
   logic [7:0] pd   = 8'h00; // Byte being programmed.
   logic [7:0] last = 8'h00; // Last byte put on the bus.
   logic [1:0] mode = 2'h0;  // Idle, program or erase.
   logic       pend = 1'b0;  // Next write is program data.
   logic       bad  = 1'b0;  // Program asks a zero to become one.
   logic       fail = 1'b0;  // Timing-limit flag.
   logic       win  = 1'b0;  // Erase window timer bit.
   logic       t6   = 1'b0;  // Primary toggle bit.
   logic       t2   = 1'b0;  // Secondary toggle bit.
   realtime    t0   = 0.0;   // Start of the running job.
   // Busy pulls the line low.
   assign ready_busy_output = (mode == 2'h0);
   // A released bus shows the inverse of the last byte, never a stale copy.
   assign dq_in = (!ce_n && !oe_n) ? last : ~last;
   // Decode each write at the end of its strobe. Chip select rises in the same
   // instant as the write strobe, so it is not looked at here.
   always @(posedge we_n)
   begin
      if (pend)
      begin
         pd = dq_out;
         bad = |(dq_out & ~mem);
         mem = mem & dq_out;
         mode = 2'h1;
         t0 = $realtime;
      end
      else if (dq_out == 8'hf0)
      begin
         mode = 2'h0;
         fail = 1'b0;
         win = 1'b0;
      end
      else if (dq_out == 8'h30 && !win)
      begin
         mem = 8'hff;
         mode = 2'h2;
         t0 = $realtime;
      end
      else if (dq_out == 8'h10 && mode == 2'h0)
      begin
         mem = 8'hff;
         mode = 2'h2;
         t0 = $realtime - WIN_NS;
      end
      pend = dq_out == 8'ha0 && mode == 2'h0;
   end
   // Each read while busy flips the primary toggle, in erase also the secondary, and may end the job.
   always @(negedge oe_n)
   begin
      if (mode == 2'h2)
      begin
         win = ($realtime - t0 >= WIN_NS);
         t2 = !t2;
      end
      if (mode == 2'h1 && $realtime - t0 >= PRG_NS && bad)
         fail = 1'b1;
      else if ((mode == 2'h1 && $realtime - t0 >= PRG_NS) ||
               (mode == 2'h2 && $realtime - t0 >= WIN_NS + ERS_NS))
         mode = 2'h0;
      t6 = t6 ^ (mode != 2'h0);
      win = win && (mode != 2'h0);
      // Program shows the complemented bit, erase a zero.
      last = (mode == 2'h0) ? mem : {(mode == 2'h1) ? ~pd[7] : 1'b0, t6, fail, 1'b0,
                                     win, t2 & (mode == 2'h2), 2'b00};
   end
endmodule : fwsr_flash_model

// >>> test_flash_write_status_reporting.sv
/*
 Self-checking bench for fwsr_ctrl: reset, a table of commands, then reject,
 mask and refusal cases. Assumes fwsr_flash_model stands on the flash pins.
*/
`timescale 1ns/1ps
module test_flash_write_status_reporting
   import fwsr_pkg::*;
;
   typedef struct packed {fwsr_cmd_e c; logic [7:0] wd; logic [2:0] ex;} fwsr_row_s;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, irq, ce_n, oe_n, we_n, rb, err, dq_oe_n;
   logic [19:0] flash_addr;
   logic [7:0]  paddr = 8'h00, dq_out, dq_in;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  en = 3'h7;
   int          n_errors = 0, checked = 0, cyc = 0;
   // Command, data byte and the event bits it should leave.
   fwsr_row_s rows [11] = '{'{C_PROG, 8'h5a, 3'h1}, '{C_PROG, 8'ha5, 3'h3},
      '{C_CHIP, 8'h00, 3'h1}, '{C_PROG, 8'ha5, 3'h1}, '{C_SERASE, 8'h00, 3'h1},
      '{C_ADD, 8'h00, 3'h1}, '{C_ADD, 8'h00, 3'h1}, '{C_ADD, 8'h00, 3'h1},
      '{C_ADD, 8'h00, 3'h1}, '{C_POLL, 8'h00, 3'h1}, '{C_RESET, 8'h00, 3'h1}};
   // A 250 MHz clock.
   always #2 pclk = !pclk;
   fwsr_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in),
      .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .ready_busy_output(rb),
      .irq(irq));
   fwsr_flash_model i_flash (.dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .dq_in(dq_in), .ready_busy_output(rb));
   // Prints the counts and the verdict, then stops.
   task results;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // Compares a seen value with the expected one.
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   // One APB transfer; holds the request until pready is sampled high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Issues one command, waits for its done or reject event and checks the events.
   task run(input fwsr_cmd_e c, input logic [7:0] wd, input logic [2:0] ex);
      logic [31:0] r;
      apb(1'b1, OFS_ADDR, 32'h100, r);
      apb(1'b1, OFS_WDATA, {24'h0, wd}, r);
      apb(1'b1, OFS_CTRL, {29'h0, c}, r);
      r = 32'h0;
      // A window found closed before the add ends with the reject event alone.
      while ((r[IRQ_DONE] | r[IRQ_REJ]) !== 1'b1)
         apb(1'b0, OFS_IRQ_ST, 32'h0, r);
      repeat (2) @(posedge pclk);
      chk("events", {29'h0, r[2:0]}, {29'h0, ex});
      chk("irq", {31'h0, irq}, {31'h0, |en});
      chk("idle pins", {11'h0, dq_oe_n, flash_addr}, 32'h100100);
      apb(1'b1, OFS_IRQ_CL, 32'h7, r);
      apb(1'b0, OFS_IRQ_ST, 32'h0, r);
      chk("cleared", {31'h0, irq}, 32'h0);
      $display("test of command %0d done", c);
   endtask : run
   // A hang counts as a mismatch.
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         n_errors++;
         results();
      end
   end
   // Reset, the table, then the awkward cases.
   initial
   begin
      repeat (12) @(posedge pclk);
      chk("reset pins", {29'h0, ce_n, pready, irq}, 32'h4);
      presetn <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0, rd);
      chk("idle", {31'h0, rd[8]}, 32'h1);
      apb(1'b0, OFS_IRQ_EN, 32'h0, rd);
      chk("irq_en reset", rd, 32'h0);
      apb(1'b1, OFS_IRQ_EN, 32'h7, rd);
      // Program, fail and recover, chip erase, sector window restarts, reset.
      foreach (rows[i])
         run(rows[i].c, rows[i].wd, rows[i].ex);
      // The window expires while erasing, so the added sector is refused.
      run(C_SERASE, 8'h00, 3'h1);
      // Erasing: pin busy, sequence accepted, window still open.
      apb(1'b0, OFS_STATUS, 32'h0, rd);
      chk("busy status", {29'h0, rd[15:13]}, 32'h2);
      repeat (500) @(posedge pclk);
      run(C_ADD, 8'h00, 3'h4);
      run(C_POLL, 8'h00, 3'h1);
      apb(1'b0, OFS_STATUS, 32'h0, rd);
      chk("ready status", {31'h0, rd[15]}, 32'h1);
      // Masked events keep the line low.
      en = 3'h0;
      apb(1'b1, OFS_IRQ_EN, 32'h0, rd);
      run(C_PROG, 8'h00, 3'h1);
      // An unmapped address is refused.
      apb(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      results();
   end
endmodule : test_flash_write_status_reporting
